// ### logic/l2rf_consts.svh
// Purpose: offsets, field positions, codes and reset values for the L2 RAM readout formatter
// Assumes: 32-bit register port, 64-bit readout words split into low and high halves
// Notes: included by bare name
`ifndef L2RF_CONSTS_SVH
`define L2RF_CONSTS_SVH

// register byte offsets on the plain register port
`define L2RF_OFS_CTRL 8'h00
`define L2RF_OFS_STATUS 8'h04
`define L2RF_OFS_RAM_W0_LO 8'h10
`define L2RF_OFS_RAM_W0_HI 8'h14
`define L2RF_OFS_RAM_W1_LO 8'h18
`define L2RF_OFS_RAM_W1_HI 8'h1C
`define L2RF_OFS_RAM_W2_LO 8'h20
`define L2RF_OFS_RAM_W2_HI 8'h24
`define L2RF_OFS_TLB_W0_LO 8'h30
`define L2RF_OFS_TLB_W0_HI 8'h34
`define L2RF_OFS_TLB_W1_LO 8'h38
`define L2RF_OFS_TLB_W1_HI 8'h3C
`define L2RF_OFS_TLB_W2_LO 8'h40
`define L2RF_OFS_TLB_W2_HI 8'h44

// ram select identifier values in location bits 31:24
`define L2RF_ID_DATA 8'h11
`define L2RF_ID_VICTIM 8'h12
`define L2RF_ID_TLB 8'h18
`define L2RF_LOC_ID_MSB 31
`define L2RF_LOC_ID_LSB 24

// reset value and unmapped-address marker
`define L2RF_WORD_RST 64'h0000000000000000
`define L2RF_ERR_CODE 32'hBAD0BAD0

`endif

// ### logic/l2rf_pkg.sv
// Purpose: types shared by the L2 RAM readout formatter
// Assumes: nothing
// Notes: constants live in l2rf_consts.svh
`default_nettype none
package l2rf_pkg;
   // raw data RAM entry with check bytes and memory tags
   typedef struct packed {
      logic [127:0] data;
      logic [7:0] check_hi;
      logic [7:0] check_lo;
      logic [3:0] memory_tag_bits;
   } l2rf_data_entry_type;

   // raw TLB entry fields
   typedef struct packed {
      logic [35:0] pa_47_12;
      logic [2:0] page_size;
      logic coalesced;
      logic [3:0] valid_bits;
      logic [15:0] address_space_identifier;
      logic [3:0] page_based_hw_attributes;
      logic walk_cache_entry;
      logic [28:0] va_48_20;
      logic non_secure;
      logic non_global_flag;
      logic outer_shareable;
      logic inner_shareable;
      logic outer_allocate;
      logic [2:0] mem_attr;
      logic [2:0] translation_regime_code;
      logic [15:0] virtual_machine_identifier;
   } l2rf_tlb_entry_type;

   // raw victim RAM entry
   typedef struct packed {
      logic [7:0] prefetch;
      logic [7:0] data_source;
      logic [7:0] transient;
      logic [7:0] outer_alloc_hint;
      logic [7:0] fill_counter;
      logic [23:0] replacement;
   } l2rf_victim_entry_type;

   // three formatted readout words
   typedef struct packed {
      logic [63:0] w2;
      logic [63:0] w1;
      logic [63:0] w0;
   } l2rf_words_type;

   typedef enum logic [1:0] {
      L2RF_SRC_DATA = 2'b00,
      L2RF_SRC_TLB = 2'b01,
      L2RF_SRC_VICTIM = 2'b10,
      L2RF_SRC_NONE = 2'b11
   } l2rf_src_type;
endpackage
`default_nettype wire

// ### logic/l2rf_tlb_pack.sv
// Purpose: packs one raw TLB entry into the three TLB readout words
// Assumes: a coalesced entry brings page 3 PA 13:12 in pa_47_12[1:0] and pages 2 to 0 in va_48_20[5:0]
// Notes: purely combinational; reserved bits forced to zero
`timescale 1ns/10ps
`default_nettype none
module l2rf_tlb_pack (
   input wire l2rf_pkg::l2rf_tlb_entry_type entry,
   output l2rf_pkg::l2rf_words_type words
);
   import l2rf_pkg::*;

   // word 0: address, page size, coalesced flag, valid bits
   always_comb begin
      words = '0;
      if (entry.coalesced) begin
         words.w0[61:28] = entry.pa_47_12[35:2];
         // pages 2 to 0 ride in the low VA bits, so word 1 echoes them at 30:25
         words.w0[27:20] = {entry.pa_47_12[1:0], entry.va_48_20[5:0]};
      end else begin
         words.w0[61:26] = entry.pa_47_12;
      end
      words.w0[19:17] = entry.page_size;
      words.w0[6] = entry.coalesced;
      words.w0[5:2] = entry.valid_bits;
      // word 1: identifier low bits, attributes, virtual address
      words.w1[63:59] = entry.address_space_identifier[4:0];
      words.w1[58:55] = entry.page_based_hw_attributes;
      words.w1[54] = entry.walk_cache_entry;
      words.w1[53:25] = entry.va_48_20;
      words.w1[20] = entry.non_secure;
      words.w1[8] = entry.non_global_flag;
      words.w1[7] = entry.outer_shareable;
      words.w1[6] = entry.inner_shareable;
      words.w1[5] = entry.outer_allocate;
      words.w1[4:2] = entry.mem_attr;
      // word 2: regime, vm identifier, upper address space identifier
      words.w2[29:27] = entry.translation_regime_code;
      words.w2[26:11] = entry.virtual_machine_identifier;
      words.w2[10:0] = entry.address_space_identifier[15:5];
   end
endmodule // l2rf_tlb_pack
`default_nettype wire

// ### logic/l2rf_formatter.sv
// Purpose: formats one entry read from the L2 data, TLB or victim RAM into readout words
// Assumes: entry inputs are valid in the cycle of rd_entry_valid; location was chosen earlier
// Notes: TLB results go to the TLB bank, data and victim results to the RAM bank
`timescale 1ns/10ps
`default_nettype none
`include "l2rf_consts.svh"
module l2rf_formatter (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [31:0] ram_location,
   input wire logic rd_entry_valid,
   input wire l2rf_pkg::l2rf_data_entry_type data_entry,
   input wire l2rf_pkg::l2rf_tlb_entry_type tlb_entry,
   input wire l2rf_pkg::l2rf_victim_entry_type victim_entry,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic readout_done
);
   import l2rf_pkg::*;

   // every check below runs on the core clock and sleeps through reset
   default clocking sys_cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   l2rf_words_type ram_words_reg;
   l2rf_words_type tlb_words_reg;
   l2rf_words_type tlb_words;
   l2rf_words_type data_words;
   l2rf_words_type victim_words;
   l2rf_src_type src;
   logic enable_reg;
   logic unknown_id_reg;
   logic [31:0] count_reg;
   logic [31:0] rdata_next;
   logic done_reg;

   // decodes the ram select identifier of a location word
   function automatic l2rf_src_type id_decode(input logic [31:0] loc);
      logic [7:0] id;
      id = loc[`L2RF_LOC_ID_MSB:`L2RF_LOC_ID_LSB];
      if (id == `L2RF_ID_DATA) return L2RF_SRC_DATA;
      else if (id == `L2RF_ID_TLB) return L2RF_SRC_TLB;
      else if (id == `L2RF_ID_VICTIM) return L2RF_SRC_VICTIM;
      else return L2RF_SRC_NONE;
   endfunction

   // selects one 32-bit half of a 64-bit readout word
   function automatic logic [31:0] half(input logic [63:0] w, input logic hi);
      return hi ? w[63:32] : w[31:0];
   endfunction

   assign src = id_decode(ram_location);

   l2rf_tlb_pack u_tlb_pack (
      .entry(tlb_entry),
      .words(tlb_words)
   );

   // data RAM layout
   always_comb begin
      data_words = '0;
      data_words.w0 = data_entry.data[63:0];
      data_words.w1 = data_entry.data[127:64];
      data_words.w2[19:12] = data_entry.check_hi;
      data_words.w2[11:4] = data_entry.check_lo;
      data_words.w2[3:0] = data_entry.memory_tag_bits;
   end

   // victim RAM layout; words 1 and 2 stay zero
   always_comb begin
      victim_words = '0;
      victim_words.w0 = {victim_entry.prefetch, victim_entry.data_source, victim_entry.transient,
                         victim_entry.outer_alloc_hint, victim_entry.fill_counter,
                         victim_entry.replacement};
   end

   // software control: bit 0 enables capture
   always_ff @(posedge clk_sys) begin
      if (!rst_n) enable_reg <= 1'b1;
      else if (reg_wr && reg_addr == `L2RF_OFS_CTRL) enable_reg <= reg_wdata[0];
   end

   // RAM bank capture; all three words rewritten together
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ram_words_reg <= {3{`L2RF_WORD_RST}};
      end else if (rd_entry_valid && enable_reg) begin
         if (src == L2RF_SRC_DATA) ram_words_reg <= data_words;
         else if (src == L2RF_SRC_VICTIM) ram_words_reg <= victim_words;
      end
   end

   // TLB bank capture
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tlb_words_reg <= {3{`L2RF_WORD_RST}};
      end else if (rd_entry_valid && enable_reg && src == L2RF_SRC_TLB) begin
         tlb_words_reg <= tlb_words;
      end
   end

   // status: readout count and sticky unknown identifier flag; the event wins over a clear
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         count_reg <= 32'h00000000;
         unknown_id_reg <= 1'b0;
      end else begin
         if (rd_entry_valid && enable_reg && src != L2RF_SRC_NONE) count_reg <= count_reg + 32'h00000001;
         if (rd_entry_valid && enable_reg && src == L2RF_SRC_NONE) unknown_id_reg <= 1'b1;
         else if (reg_wr && reg_addr == `L2RF_OFS_STATUS && reg_wdata[0]) unknown_id_reg <= 1'b0;
      end
   end

   // one-cycle done pulse after a capture
   always_ff @(posedge clk_sys) begin
      if (!rst_n) done_reg <= 1'b0;
      else done_reg <= rd_entry_valid && enable_reg && src != L2RF_SRC_NONE;
   end
   assign readout_done = done_reg;

   // read decode; unmapped addresses answer a fixed marker
   always_comb begin
      unique case (reg_addr)
         `L2RF_OFS_CTRL: rdata_next = {31'h00000000, enable_reg};
         `L2RF_OFS_STATUS: rdata_next = {count_reg[30:0], unknown_id_reg};
         `L2RF_OFS_RAM_W0_LO, `L2RF_OFS_RAM_W0_HI: rdata_next = half(ram_words_reg.w0, reg_addr[2]);
         `L2RF_OFS_RAM_W1_LO, `L2RF_OFS_RAM_W1_HI: rdata_next = half(ram_words_reg.w1, reg_addr[2]);
         `L2RF_OFS_RAM_W2_LO, `L2RF_OFS_RAM_W2_HI: rdata_next = half(ram_words_reg.w2, reg_addr[2]);
         `L2RF_OFS_TLB_W0_LO, `L2RF_OFS_TLB_W0_HI: rdata_next = half(tlb_words_reg.w0, reg_addr[2]);
         `L2RF_OFS_TLB_W1_LO, `L2RF_OFS_TLB_W1_HI: rdata_next = half(tlb_words_reg.w1, reg_addr[2]);
         `L2RF_OFS_TLB_W2_LO, `L2RF_OFS_TLB_W2_HI: rdata_next = half(tlb_words_reg.w2, reg_addr[2]);
         default: rdata_next = `L2RF_ERR_CODE;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (!rst_n) reg_rdata <= 32'h00000000;
      else if (reg_rd) reg_rdata <= rdata_next;
      else reg_rdata <= 32'h00000000;
   end

   // capture qualifiers for the checks; they restate the bank enables so a slip there shows
   logic cap_data;
   logic cap_tlb;
   logic cap_victim;
   logic cap_known;
   logic cap_unknown;
   assign cap_data = rd_entry_valid && enable_reg && src == L2RF_SRC_DATA;
   assign cap_tlb = rd_entry_valid && enable_reg && src == L2RF_SRC_TLB;
   assign cap_victim = rd_entry_valid && enable_reg && src == L2RF_SRC_VICTIM;
   assign cap_known = cap_data || cap_tlb || cap_victim;
   assign cap_unknown = rd_entry_valid && enable_reg && src == L2RF_SRC_NONE;

   // data RAM layout checks
   a_data_words: assert property (
      cap_data
      |=> ram_words_reg.w1 == $past(data_entry.data[127:64]) && ram_words_reg.w0 == $past(data_entry.data[63:0]))
      else $error("data words wrong");
   a_data_check: assert property (
      cap_data
      |=> ram_words_reg.w2[19:12] == $past(data_entry.check_hi) && ram_words_reg.w2[63:20] == 44'h0)
      else $error("data word 2 wrong");
   a_data_low_check: assert property (
      cap_data
      |=> ram_words_reg.w2[11:4] == $past(data_entry.check_lo))
      else $error("lower check byte wrong");
   a_data_tags: assert property (
      cap_data
      |=> ram_words_reg.w2[3:0] == $past(data_entry.memory_tag_bits))
      else $error("memory tag bits wrong");

   // TLB word 0 checks
   a_tlb_plain: assert property (
      cap_tlb && !tlb_entry.coalesced
      |=> tlb_words_reg.w0[61:26] == $past(tlb_entry.pa_47_12) && tlb_words_reg.w0[25:20] == 6'h00)
      else $error("tlb pa wrong");
   a_tlb_coal_pa: assert property (
      cap_tlb && tlb_entry.coalesced
      |=> tlb_words_reg.w0[61:26] == $past(tlb_entry.pa_47_12))
      else $error("coalesced pa wrong");
   a_tlb_low_pages: assert property (
      cap_tlb && tlb_entry.coalesced
      |=> tlb_words_reg.w0[25:20] == $past(tlb_entry.va_48_20[5:0]))
      else $error("coalesced page bits wrong");
   a_tlb_size: assert property (
      cap_tlb
      |=> tlb_words_reg.w0[19:17] == $past(tlb_entry.page_size))
      else $error("page size wrong");
   a_tlb_flags: assert property (
      cap_tlb
      |=> tlb_words_reg.w0[6] == $past(tlb_entry.coalesced) && tlb_words_reg.w0[16:7] == 10'h000)
      else $error("tlb flags wrong");
   a_tlb_valid: assert property (
      cap_tlb
      |=> tlb_words_reg.w0[5:2] == $past(tlb_entry.valid_bits))
      else $error("valid bits wrong");
   a_tlb_w0_rsv: assert property (
      cap_tlb
      |=> tlb_words_reg.w0[63:62] == 2'h0 && tlb_words_reg.w0[1:0] == 2'h0)
      else $error("tlb word 0 reserved bits set");

   // TLB word 1 checks
   a_tlb_space_lo: assert property (
      cap_tlb
      |=> tlb_words_reg.w1[63:59] == $past(tlb_entry.address_space_identifier[4:0]))
      else $error("low space id wrong");
   a_tlb_page_attrs: assert property (
      cap_tlb
      |=> tlb_words_reg.w1[58:55] == $past(tlb_entry.page_based_hw_attributes))
      else $error("page attributes wrong");
   a_tlb_walk_flag: assert property (
      cap_tlb
      |=> tlb_words_reg.w1[54] == $past(tlb_entry.walk_cache_entry))
      else $error("walk flag wrong");
   a_tlb_virt_addr: assert property (
      cap_tlb
      |=> tlb_words_reg.w1[53:25] == $past(tlb_entry.va_48_20) && tlb_words_reg.w1[20] == $past(tlb_entry.non_secure))
      else $error("va or non-secure wrong");
   a_tlb_non_global: assert property (
      cap_tlb
      |=> tlb_words_reg.w1[8] == $past(tlb_entry.non_global_flag))
      else $error("non global wrong");
   a_tlb_shareable: assert property (
      cap_tlb
      |=> tlb_words_reg.w1[7] == $past(tlb_entry.outer_shareable) && tlb_words_reg.w1[6] == $past(tlb_entry.inner_shareable))
      else $error("shareable bits wrong");
   a_tlb_outer_alloc: assert property (
      cap_tlb
      |=> tlb_words_reg.w1[5] == $past(tlb_entry.outer_allocate))
      else $error("outer allocate wrong");
   a_tlb_attrs: assert property (
      cap_tlb
      |=> tlb_words_reg.w1[4:2] == $past(tlb_entry.mem_attr))
      else $error("mem attr wrong");
   a_tlb_w1_rsv: assert property (
      cap_tlb
      |=> tlb_words_reg.w1[24:21] == 4'h0 && tlb_words_reg.w1[19:9] == 11'h000 && tlb_words_reg.w1[1:0] == 2'h0)
      else $error("tlb word 1 reserved bits set");

   // TLB word 2 checks
   a_tlb_regime: assert property (
      cap_tlb
      |=> tlb_words_reg.w2[29:27] == $past(tlb_entry.translation_regime_code))
      else $error("regime wrong");
   a_tlb_vm_ident: assert property (
      cap_tlb
      |=> tlb_words_reg.w2[26:11] == $past(tlb_entry.virtual_machine_identifier))
      else $error("vm identifier wrong");
   a_tlb_space_hi: assert property (
      cap_tlb
      |=> tlb_words_reg.w2[10:0] == $past(tlb_entry.address_space_identifier[15:5]))
      else $error("high space id wrong");
   a_tlb_w2_rsv: assert property (
      cap_tlb
      |=> tlb_words_reg.w2[63:30] == 34'h0)
      else $error("tlb word 2 reserved bits set");

   // victim RAM layout checks
   a_victim_zero: assert property (
      cap_victim
      |=> ram_words_reg.w1 == 64'h0 && ram_words_reg.w2 == 64'h0)
      else $error("victim upper words not zero");
   a_victim_w0: assert property (
      cap_victim
      |=> ram_words_reg.w0[23:0] == $past(victim_entry.replacement))
      else $error("victim word 0 wrong");
   a_victim_upper: assert property (
      cap_victim
      |=> ram_words_reg.w0[63:56] == $past(victim_entry.prefetch) && ram_words_reg.w0[55:48] == $past(victim_entry.data_source))
      else $error("victim prefetch or source wrong");
   a_victim_mid: assert property (
      cap_victim
      |=> ram_words_reg.w0[47:40] == $past(victim_entry.transient) && ram_words_reg.w0[39:32] == $past(victim_entry.outer_alloc_hint))
      else $error("victim transient or hint wrong");
   a_victim_counter: assert property (
      cap_victim
      |=> ram_words_reg.w0[31:24] == $past(victim_entry.fill_counter))
      else $error("victim fill counter wrong");

   // bank hold and done pulse checks
   a_ram_hold: assert property (
      !cap_data && !cap_victim
      |=> $stable(ram_words_reg))
      else $error("ram bank changed without capture");
   a_tlb_hold: assert property (
      !cap_tlb
      |=> $stable(tlb_words_reg))
      else $error("tlb bank changed without capture");
   a_done_pulse: assert property (
      cap_known
      |=> readout_done ##1 (!readout_done || $past(cap_known)))
      else $error("done pulse wrong");
   a_done_quiet: assert property (
      !cap_known
      |=> !readout_done)
      else $error("done without capture");

   // status, control and read port checks
   a_count_step: assert property (
      cap_known
      |=> count_reg == $past(count_reg) + 32'h00000001)
      else $error("capture count did not step");
   a_count_hold: assert property (
      !cap_known
      |=> $stable(count_reg))
      else $error("capture count moved");
   a_unknown_set: assert property (
      cap_unknown
      |=> unknown_id_reg)
      else $error("unknown id flag not set");
   a_unknown_clear: assert property (
      !cap_unknown && reg_wr && reg_addr == `L2RF_OFS_STATUS && reg_wdata[0]
      |=> !unknown_id_reg)
      else $error("unknown id flag not cleared");
   a_ctrl_write: assert property (
      reg_wr && reg_addr == `L2RF_OFS_CTRL
      |=> enable_reg == $past(reg_wdata[0]))
      else $error("capture enable not written");
   a_enable_hold: assert property (
      !(reg_wr && reg_addr == `L2RF_OFS_CTRL)
      |=> $stable(enable_reg))
      else $error("capture enable moved");
   a_rdata_idle: assert property (
      !reg_rd
      |=> reg_rdata == 32'h00000000)
      else $error("read data outside its cycle");

   // scenario covers
   c_data: cover property (@(posedge clk_sys) rd_entry_valid && src == L2RF_SRC_DATA);
   c_tlb_coal: cover property (@(posedge clk_sys) rd_entry_valid && src == L2RF_SRC_TLB && tlb_entry.coalesced);
   c_victim: cover property (@(posedge clk_sys) rd_entry_valid && src == L2RF_SRC_VICTIM);
   c_unknown: cover property (@(posedge clk_sys) cap_unknown);
   c_disabled: cover property (@(posedge clk_sys) rd_entry_valid && !enable_reg);
endmodule // l2rf_formatter
`default_nettype wire

// ### test/l2rf_formatter_tb.sv
// Purpose: self-checking bench for the L2 RAM readout formatter
// Assumes: register port reads answer in the cycle after the read strobe
// Notes: expected words are built here from field positions, never from design outputs
`timescale 1ns/10ps
`default_nettype none
`include "l2rf_consts.svh"
module l2rf_formatter_tb;
   import l2rf_pkg::*;
   logic clk_sys;
   logic rst_n;
   logic [31:0] ram_location;
   logic rd_entry_valid;
   l2rf_data_entry_type data_entry;
   l2rf_tlb_entry_type tlb_entry;
   l2rf_victim_entry_type victim_entry;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic readout_done;
   int failures;
   int checks_done;
   l2rf_words_type exp_ram;
   l2rf_tlb_entry_type tlb_next;
   logic [2:0] size_tab [7];
   logic [2:0] regime_tab [7];

   l2rf_formatter i_l2rf_formatter (
      .clk_sys(clk_sys), .rst_n(rst_n), .ram_location(ram_location), .rd_entry_valid(rd_entry_valid),
      .data_entry(data_entry), .tlb_entry(tlb_entry), .victim_entry(victim_entry), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .readout_done(readout_done)
   );

   // 125 MHz clock
   always #4 clk_sys = ~clk_sys;

   // single place where the run ends
   task automatic give_verdict();
      if (failures == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // masked compare; case inequality so an unknown never matches
   task automatic check32(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
      checks_done++;
      if ((got & mask) !== (exp & mask)) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // read data is only valid in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      check32(reg_rdata, exp, mask);
   endtask

   // low half at the offset, high half four bytes above
   task automatic check_bank(input logic [7:0] base, input l2rf_words_type w);
      for (int k = 0; k < 6; k++) begin
         rd(base + 8'(4 * k), w[32 * k +: 32], 32'hFFFFFFFF);
      end
   endtask

   // one-cycle capture pulse; done is looked at in the single cycle it stands
   task automatic capture(input logic [31:0] loc, input logic exp_done);
      @(posedge clk_sys);
      ram_location <= loc;
      rd_entry_valid <= 1'b1;
      @(posedge clk_sys);
      rd_entry_valid <= 1'b0;
      #1;
      check32({31'h0, readout_done}, {31'h0, exp_done}, 32'h1);
   endtask

   // reference layout of the three TLB words
   function automatic l2rf_words_type tlb_fmt(input l2rf_tlb_entry_type e);
      l2rf_words_type w;
      w.w0 = {2'h0, e.pa_47_12, 6'h00, e.page_size, 10'h000, e.coalesced, e.valid_bits, 2'h0};
      if (e.coalesced) begin
         w.w0[25:20] = e.va_48_20[5:0];
      end
      w.w1 = {e.address_space_identifier[4:0], e.page_based_hw_attributes, e.walk_cache_entry, e.va_48_20,
              4'h0, e.non_secure, 11'h000, e.non_global_flag, e.outer_shareable, e.inner_shareable,
              e.outer_allocate, e.mem_attr, 2'h0};
      w.w2 = {34'h0, e.translation_regime_code, e.virtual_machine_identifier, e.address_space_identifier[15:5]};
      return w;
   endfunction

   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (100000) @(posedge clk_sys);
      failures++;
      give_verdict();
   end

   initial begin
      clk_sys = 1'b0;
      rst_n = 1'b0;
      ram_location = 32'h00000000;
      rd_entry_valid = 1'b0;
      data_entry = '0;
      tlb_entry = '0;
      victim_entry = '0;
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      failures = 0;
      checks_done = 0;
      size_tab = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
      regime_tab = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h0, 3'h3};
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      // reset values, read-only words and an unmapped offset
      exp_ram = '0;
      check_bank(`L2RF_OFS_RAM_W0_LO, exp_ram);
      check_bank(`L2RF_OFS_TLB_W0_LO, exp_ram);
      rd(`L2RF_OFS_CTRL, 32'h00000001, 32'h00000001);
      rd(`L2RF_OFS_STATUS, 32'h00000000, 32'hFFFFFFFF);
      rd(8'hFC, `L2RF_ERR_CODE, 32'hFFFFFFFF);
      wr(`L2RF_OFS_RAM_W0_LO, 32'hFFFFFFFF);
      rd(`L2RF_OFS_RAM_W0_LO, 32'h00000000, 32'hFFFFFFFF);
      // data RAM entry, location bits 5:4 set but not decoded
      data_entry <= {128'hFEDCBA98_76543210_0F1E2D3C_4B5A6978, 8'hA5, 8'h3C, 4'h9};
      capture({`L2RF_ID_DATA, 24'h000030}, 1'b1);
      exp_ram.w0 = 64'h0F1E2D3C_4B5A6978;
      exp_ram.w1 = 64'hFEDCBA98_76543210;
      exp_ram.w2 = {44'h0, 8'hA5, 8'h3C, 4'h9};
      check_bank(`L2RF_OFS_RAM_W0_LO, exp_ram);
      // page sizes 0 to 2 and 4 to 7, memory attributes 1 to 7, regimes 0 to 3 and 5; coalesced on odd passes
      tlb_next = 121'h1_2345_6789_ABCD_EF01_2345_6789_ABCD_EF;
      for (int i = 0; i < 7; i++) begin
         tlb_next.page_size = size_tab[i];
         tlb_next.coalesced = i[0];
         tlb_next.valid_bits = 4'(i + 9);
         tlb_next.mem_attr = 3'(i + 1);
         tlb_next.translation_regime_code = regime_tab[i];
         tlb_entry <= tlb_next;
         capture({`L2RF_ID_TLB, 24'h0400A5}, 1'b1);
         check_bank(`L2RF_OFS_TLB_W0_LO, tlb_fmt(tlb_next));
      end
      // a TLB readout leaves the RAM bank alone
      check_bank(`L2RF_OFS_RAM_W0_LO, exp_ram);
      // victim after data: words 1 and 2 must be cleared
      victim_entry <= 64'h8172_6354_4536_2718;
      capture({`L2RF_ID_VICTIM, 24'h000000}, 1'b1);
      exp_ram = '0;
      exp_ram.w0 = 64'h8172_6354_4536_2718;
      check_bank(`L2RF_OFS_RAM_W0_LO, exp_ram);
      // unknown identifier: no done, words kept, sticky flag set then cleared
      data_entry <= '1;
      capture(32'h55000000, 1'b0);
      check_bank(`L2RF_OFS_RAM_W0_LO, exp_ram);
      // nine known captures so far: count 9 above the sticky flag
      rd(`L2RF_OFS_STATUS, 32'h00000013, 32'hFFFFFFFF);
      wr(`L2RF_OFS_STATUS, 32'h00000001);
      rd(`L2RF_OFS_STATUS, 32'h00000012, 32'hFFFFFFFF);
      // capture disabled: request ignored
      wr(`L2RF_OFS_CTRL, 32'h00000000);
      rd(`L2RF_OFS_CTRL, 32'h00000000, 32'h00000001);
      capture({`L2RF_ID_DATA, 24'h000000}, 1'b0);
      check_bank(`L2RF_OFS_RAM_W0_LO, exp_ram);
      rd(`L2RF_OFS_STATUS, 32'h00000012, 32'hFFFFFFFF);
      // mid-run reset: both banks clear, status clears and capture comes back enabled
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      exp_ram = '0;
      check_bank(`L2RF_OFS_RAM_W0_LO, exp_ram);
      check_bank(`L2RF_OFS_TLB_W0_LO, exp_ram);
      rd(`L2RF_OFS_CTRL, 32'h00000001, 32'h00000001);
      rd(`L2RF_OFS_STATUS, 32'h00000000, 32'hFFFFFFFF);
      give_verdict();
   end
endmodule // l2rf_formatter_tb
`default_nettype wire
